// File: shared/rvt_defs.vh
// Constants for the rail voltage I2C target register block.
`ifndef RVT_DEFS_VH
`define RVT_DEFS_VH
`define RVT_DEV_ADDR 7'h3e
`define RVT_SUB_POS 8'h00
`define RVT_SUB_NEG 8'h01
`define RVT_SUB_OPT 8'h03
`define RVT_CODE_W 5
`define RVT_LAST_BIT 4'h7
`define RVT_CODE_MIN 5'h01
`define RVT_CODE_MAX 5'h11
`define RVT_CODE_DEF_A 5'h0a
`define RVT_CODE_DEF_B 5'h0e
`define RVT_OPT_RESET 8'hff
`define RVT_OPT_KEEP 8'h03
`endif

// File: design/rvt_pin_sync.v
// Three-stage synchroniser with agreement filter for one pin.
`timescale 1ns/10ps
`default_nettype none
module rvt_pin_sync (
  input wire clk_sys,
  input wire rst,
  input wire pin_in,
  input wire rst_val,
  output reg level_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge clk_sys) begin
    if (rst) begin
      s1_r <= rst_val;
      s2_r <= rst_val;
      s3_r <= rst_val;
      level_r <= rst_val;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // The filtered level moves only when the last two stages agree.
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
endmodule
`default_nettype wire

// File: design/rvt_target.v
// Write-only I2C target holding the positive and negative rail voltage codes.
`timescale 1ns/10ps
`default_nettype none
`include "rvt_defs.vh"
module rvt_target #(
  parameter VARIANT_B = 0
) (
  input wire clk_sys,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  input wire first_enable_input,
  input wire second_enable_input,
  output reg [4:0] positive_rail_code,
  output reg [4:0] negative_rail_code,
  output reg [7:0] operating_options,
  output reg busy_r
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_SUB = 3'd3;
  localparam ST_DATA = 3'd4;
  localparam ST_SKIP = 3'd5;

  wire scl_s;
  wire sda_s;
  reg scl_d_r;
  reg sda_d_r;
  reg [2:0] state_r;
  reg [2:0] next_after_ack_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [7:0] sub_r;
  reg have_sub_r;
  reg ack_drive_r;
  wire enabled;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire [7:0] byte_in;
  wire first_enable_s;
  wire second_enable_s;

  rvt_pin_sync u_scl (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(scl_in),
    .rst_val(1'b1),
    .level_r(scl_s)
  );
  rvt_pin_sync u_sda (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(sda_in),
    .rst_val(1'b1),
    .level_r(sda_s)
  );

  // The enable pins have pull-downs, so standby is the level assumed out of reset.
  rvt_pin_sync u_first_enable (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(first_enable_input),
    .rst_val(1'b0),
    .level_r(first_enable_s)
  );
  rvt_pin_sync u_second_enable (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(second_enable_input),
    .rst_val(1'b0),
    .level_r(second_enable_s)
  );

  // Either enable pin wakes the interface; with both low it stays in standby.
  assign enabled = first_enable_s | second_enable_s;
  // Edges come from the filtered levels, so a one-clock glitch never counts.
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_cond = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign byte_in = {shift_r[6:0], sda_s};
  // Open drain: only ever pull low, output enable active low.
  assign sda_out = 1'b0;
  assign sda_oe_n = ~ack_drive_r;

  function [4:0] rvt_default;
    input integer variant;
    begin
      rvt_default = (variant != 0) ? `RVT_CODE_DEF_B : `RVT_CODE_DEF_A;
    end
  endfunction

  // Keeps the five code bits; a code outside the valid range is stored as sent.
  function [4:0] rvt_code_field;
    input [7:0] data;
    begin
      rvt_code_field = data[`RVT_CODE_W-1:0];
    end
  endfunction

  // The direction bit is part of the match, so a read header is never answered.
  function rvt_addr_hit;
    input [7:0] hdr;
    begin
      rvt_addr_hit = (hdr == {`RVT_DEV_ADDR, 1'b0});
    end
  endfunction

  always @(posedge clk_sys) begin
    if (rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      state_r <= ST_IDLE;
      next_after_ack_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      sub_r <= 8'h00;
      have_sub_r <= 1'b0;
      ack_drive_r <= 1'b0;
      busy_r <= 1'b0;
      // Both codes come back to the variant default, whatever was written before.
      positive_rail_code <= rvt_default(VARIANT_B);
      negative_rail_code <= rvt_default(VARIANT_B);
      operating_options <= `RVT_OPT_RESET;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      if (!enabled) begin
        // A transfer cut by standby is dropped and the line released.
        state_r <= ST_IDLE;
        ack_drive_r <= 1'b0;
        busy_r <= 1'b0;
      end else if (stop_cond) begin
        state_r <= ST_IDLE;
        ack_drive_r <= 1'b0;
        busy_r <= 1'b0;
      end else if (start_cond) begin
        // Repeated start restarts the address phase.
        state_r <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        have_sub_r <= 1'b0;
        ack_drive_r <= 1'b0;
        busy_r <= 1'b1;
      end else begin
        case (state_r)
          ST_IDLE: begin
            ack_drive_r <= 1'b0;
          end
          ST_ADDR, ST_SUB, ST_DATA: begin
            if (scl_rise) begin
              shift_r <= byte_in;
              bit_cnt_r <= bit_cnt_r + 4'h1;
              if (bit_cnt_r == `RVT_LAST_BIT) begin
                bit_cnt_r <= 4'h0;
                state_r <= ST_ACK;
                if (state_r == ST_ADDR) begin
                  if (rvt_addr_hit(byte_in)) begin
                    next_after_ack_r <= ST_SUB;
                  end else begin
                    state_r <= ST_SKIP;
                  end
                end else if (state_r == ST_SUB) begin
                  sub_r <= byte_in;
                  have_sub_r <= 1'b1;
                  next_after_ack_r <= ST_DATA;
                end else begin
                  // The two codes keep only the low five bits; the options byte is stored whole.
                  // A byte lands only once a sub-address has been taken in this transfer.
                  if (have_sub_r && sub_r == `RVT_SUB_POS) begin
                    positive_rail_code <= rvt_code_field(byte_in);
                  end else if (have_sub_r && sub_r == `RVT_SUB_NEG) begin
                    negative_rail_code <= rvt_code_field(byte_in);
                  end else if (have_sub_r && sub_r == `RVT_SUB_OPT) begin
                    // Bits 1:0 are kept as written; the controller must leave them set.
                    operating_options <= byte_in;
                  end
                  sub_r <= sub_r + 8'h01;
                  next_after_ack_r <= ST_DATA;
                end
              end
            end
          end
          ST_ACK: begin
            // Pull low from the eighth fall to the ninth fall.
            if (scl_fall) begin
              if (ack_drive_r) begin
                ack_drive_r <= 1'b0;
                state_r <= next_after_ack_r;
              end else begin
                ack_drive_r <= 1'b1;
              end
            end
          end
          // A foreign header leaves the target silent until the next start or stop.
          ST_SKIP: begin
            ack_drive_r <= 1'b0;
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/rvt_i2c_host.sv
// Behavioural I2C bus controller that writes to the target.
`timescale 1ns/10ps
`default_nettype none
module rvt_i2c_host (
  input wire logic clk_sys,
  input wire logic sda_bus,
  output logic scl,
  output logic sda_drv
);
  logic nak_r = 1'b0;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic step(input int n, input logic c, input logic d);
    repeat (n) @(negedge clk_sys);
    scl = c;
    sda_drv = d;
  endtask
  // Data moves one clock before the rise, so each bit settles ahead of the target's sample.
  // Eight clocks a bit is faster than the bus limit; the target has no timing checks.
  task automatic bit_out(input logic d);
    step(4, 1'b0, d);
    step(1, 1'b1, d);
    step(2, 1'b1, d);
    nak_r = sda_bus;
    step(1, 1'b0, d);
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    bit_out(1'b1);
  endtask
  task automatic start();
    step(1, 1'b1, 1'b1);
    step(4, 1'b1, 1'b0);
    step(6, 1'b0, 1'b0);
  endtask
  task automatic stop();
    step(4, 1'b0, 1'b0);
    step(1, 1'b1, 1'b0);
    step(4, 1'b1, 1'b1);
  endtask
endmodule
`default_nettype wire

// File: verif/rvt_chk.sv
// Assertions on the rail voltage target's pins.
`timescale 1ns/10ps
`default_nettype none
`include "rvt_defs.vh"
module rvt_chk #(parameter VARIANT_B = 0) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic first_enable_input,
  input wire logic second_enable_input,
  input wire logic [4:0] positive_rail_code,
  input wire logic [4:0] negative_rail_code,
  input wire logic [7:0] operating_options,
  input wire logic busy_r
);
  localparam logic [4:0] DEF = VARIANT_B ? `RVT_CODE_DEF_B : `RVT_CODE_DEF_A;
  wire logic off = !(first_enable_input | second_enable_input);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_rst_vals: assert property (disable iff (1'b0) rst |=> positive_rail_code == DEF
    && negative_rail_code == DEF && operating_options == 8'hff) else $error("reset values");
  a_off_silent: assert property (off [*6] |-> sda_oe_n && !busy_r)
    else $error("active in standby");
  a_off_keep: assert property (off [*6] |=> $stable(positive_rail_code)
    && $stable(negative_rail_code)) else $error("write in standby");
  a_idle_pos: assert property (!busy_r |=> $stable(positive_rail_code))
    else $error("code moved outside transfer");
  a_idle_neg: assert property (!busy_r |=> $stable(negative_rail_code))
    else $error("negative code moved outside transfer");
  a_idle_opt: assert property (!busy_r |=> $stable(operating_options))
    else $error("options moved outside transfer");
  a_ack_busy: assert property (!sda_oe_n |-> busy_r) else $error("ack while idle");
  a_ack_low: assert property ($fell(sda_oe_n) |-> !$past(scl_in, 3))
    else $error("ack began with clock high");
  a_ack_span: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*6] ##[1:6] sda_oe_n)
    else $error("ack length");
  a_pin_zero: assert property (sda_out == 1'b0) else $error("data pin driven high");
endmodule
bind rvt_target rvt_chk #(.VARIANT_B(VARIANT_B)) u_rvt_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe_n(sda_oe_n),
  .first_enable_input(first_enable_input),
  .second_enable_input(second_enable_input),
  .positive_rail_code(positive_rail_code),
  .negative_rail_code(negative_rail_code),
  .operating_options(operating_options),
  .busy_r(busy_r)
);
`default_nettype wire

// File: verif/test_rvt_target.sv
// Self-checking bench for the rail voltage target.
`timescale 1ns/10ps
`default_nettype none
`include "rvt_defs.vh"
module test_rvt_target;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic first_enable = 1'b1;
  logic second_enable = 1'b0;
  wire logic scl;
  wire logic host_sda;
  wire logic sda_out;
  wire logic sda_oe_n;
  wire logic busy;
  wire logic [4:0] pos;
  wire logic [4:0] neg;
  wire logic [7:0] opt;
  // The line has a pull-up, so it is low whenever either party pulls it.
  wire logic sda = host_sda & (sda_oe_n | sda_out);
  int bad_count = 0;
  int checked = 0;
  always #50 clk_sys = ~clk_sys;
  rvt_i2c_host u_rvt_i2c_host (.clk_sys(clk_sys), .sda_bus(sda), .scl(scl), .sda_drv(host_sda));
  rvt_target u_rvt_target (.clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .first_enable_input(first_enable),
    .second_enable_input(second_enable), .positive_rail_code(pos), .negative_rail_code(neg),
    .operating_options(opt), .busy_r(busy));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Address, then sub-address and four data bytes; nak is the expected answer.
  task automatic write(input logic [7:0] a, input logic [39:0] b, input logic nak);
    u_rvt_i2c_host.start();
    u_rvt_i2c_host.send(a);
    check(u_rvt_i2c_host.nak_r, nak);
    for (int i = 0; i < 5; i++) begin
      u_rvt_i2c_host.send(b[39-8*i -: 8]);
      check(u_rvt_i2c_host.nak_r, nak);
    end
    u_rvt_i2c_host.stop();
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    repeat (5) @(negedge clk_sys);
    check({3'h0, pos}, {3'h0, `RVT_CODE_DEF_A});
    check(opt, `RVT_OPT_RESET);
    write(8'h7c, 40'h00e51155f7, 1'b0);
    check({3'h0, pos}, 8'h05);
    check({3'h0, neg}, 8'h11);
    check(opt, 8'hf7);
    write(8'hfc, 40'h0001010101, 1'b1);
    write(8'h7a, 40'h0001010101, 1'b1);
    check({3'h0, pos}, 8'h05);
    first_enable = 1'b0;
    repeat (10) @(negedge clk_sys);
    write(8'h7c, 40'h0001010101, 1'b1);
    check({3'h0, neg}, 8'h11);
    check({3'h0, pos}, 8'h05);
    second_enable = 1'b1;
    repeat (10) @(negedge clk_sys);
    write(8'h7c, 40'h01012aff07, 1'b0);
    check({3'h0, neg}, {3'h0, `RVT_CODE_MIN});
    check(opt, 8'hff);
    check({3'h0, pos}, 8'h05);
    rst = 1'b1;
    @(negedge clk_sys);
    rst = 1'b0;
    repeat (5) @(negedge clk_sys);
    check({3'h0, neg}, {3'h0, `RVT_CODE_DEF_A});
    check({3'h0, pos}, {3'h0, `RVT_CODE_DEF_A});
    check(opt, `RVT_OPT_RESET);
    tally_and_finish();
  end
endmodule
`default_nettype wire
